// ### core/pllcm_pkg.sv
// Constants and types shared by the PLL clock module
package pllcm_pkg;

    // Clock rate and lock timing
    localparam int unsigned CLK_FREQ_MHZ   = 100;
    localparam int unsigned LOCK_TIME_US   = 1000;
    localparam int unsigned LOCK_CYCLES    = LOCK_TIME_US * CLK_FREQ_MHZ;
    localparam int unsigned LOCK_CNT_W     = 17;

    // APB register byte addresses
    localparam logic [7:0]  ADDR_CLK_OUT   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [7:0]  ADDR_CLK_CTRL  = 8'h08;
    localparam logic [7:0]  ADDR_RATIO     = 8'h0C;

    // clock_output_ctrl_reg fields
    localparam int unsigned POS_PIN_SEL    = 0;

    // pll_status_reg fields
    localparam int unsigned POS_LOCK       = 0;
    localparam int unsigned POS_POWER_OFF  = 1;
    localparam int unsigned POS_DIV_SEL    = 2;

    // clock_control_reg fields
    localparam int unsigned POS_EXT_OFF    = 0;
    localparam int unsigned POS_XTAL_OFF   = 1;
    localparam int unsigned POS_OSC_A_OFF  = 2;
    localparam int unsigned POS_OSC_B_OFF  = 3;
    localparam int unsigned POS_CORE_SRC   = 4;
    localparam int unsigned POS_WDOG_OSC   = 6;
    localparam int unsigned POS_TIMER_OSC  = 7;

    // pll_ratio_reg field and limits
    localparam int unsigned RATIO_W        = 4;
    localparam logic [3:0]  RATIO_BYPASS   = 4'h0;
    localparam logic [3:0]  RATIO_MAX      = 4'hC;

    // Reset values
    localparam logic [1:0]  DIV_SEL_RESET  = 2'h0;
    localparam logic [1:0]  CORE_SRC_RESET = 2'h0;

    // Post-divider encodings and divide factors
    localparam logic [1:0]  DIV_SEL_BY2    = 2'h2;
    localparam logic [1:0]  DIV_SEL_BY1    = 2'h3;
    localparam logic [2:0]  DIV_BY4        = 3'h4;
    localparam logic [2:0]  DIV_BY2        = 3'h2;
    localparam logic [2:0]  DIV_BY1        = 3'h1;

    // Core clock sources
    localparam logic [1:0]  SRC_OSC_A      = 2'h0;
    localparam logic [1:0]  SRC_OSC_B      = 2'h1;
    localparam logic [1:0]  SRC_XTAL       = 2'h2;
    localparam logic [1:0]  SRC_EXT        = 2'h3;

    typedef enum logic [1:0] {
        PLLCM_BYPASS,
        PLLCM_LOCKING,
        PLLCM_ACTIVE,
        PLLCM_OFF
    } pllcm_mode_t;

endpackage

// ### core/pllcm_top.sv
// PLL clock module: mode control, lock timing, source selection, APB regs
// Function
// (R1) A 4-bit ratio field sets the integer multiplication factor.
// (R2) Software disables the watchdog before writing the ratio.
// (R3) Software waits 1 ms for the PLL to settle before re-arming the watchdog.
// (R4) Software keeps the VCO output at 50 MHz or more.
// (R5) Ratio 0 bypasses the PLL; ratios 1 to 12 give source times n over div.
// (R6) Divider select 0 or 1 divides by 4, 2 by 2, 3 by 1; reset is by 4.
// (R7) Software zeroes the divider select before a ratio write, then waits lock.
// (R8) Ratio and status state reset only on pin reset or watchdog reset.
// (R9) Watchdog, core and timer clocks each pick either internal oscillator; the core clock here can also pick the crystal or the external input.
// (R10) The external clock input comes from pin 19 or pin 38 per a select bit.
// (R11) The external-input-off bit forces the external clock input low.
// (R12) Software confirms the target clock runs before switching sources.
// (R13) The power-off bit powers down the PLL; ratio must be zero first.
// (R14) With the PLL off the CPU clock is the source over the post-divider.
// (R15) Bypass with the PLL powered is the state after reset.
// (R16) A ratio write forces bypass until the PLL reports lock.
// (R17) The lock flag clears on a ratio write and sets once switched in.
`timescale 1ns/10ps
module pllcm_top
    import pllcm_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES_P = LOCK_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        wdog_reset_i,
    input  wire logic        dbg_reset_i,
    input  wire logic        mclk_reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        gpio19_i,
    input  wire logic        gpio38_i,
    output logic             ext_clock_input_o,
    output logic      [3:0]  cpu_mult_o,
    output logic      [2:0]  cpu_div_o,
    output logic             pll_powered_o,
    output logic             pll_bypass_o,
    output logic             lock_flag_o,
    output logic      [1:0]  core_src_o,
    output logic             wdog_osc_b_o,
    output logic             timer_osc_b_o,
    output logic             xtal_enable_o,
    output logic             osc_a_enable_o,
    output logic             osc_b_enable_o
);

    typedef struct packed {
        logic                  pin19_meta;
        logic                  pin19_sync;
        logic                  pin38_meta;
        logic                  pin38_sync;
        logic                  ext_clk;
        logic                  pin_sel;
        logic                  ext_off;
        logic                  xtal_off;
        logic                  osc_a_off;
        logic                  osc_b_off;
        logic [1:0]            core_src;
        logic                  wdog_osc;
        logic                  timer_osc;
        logic [RATIO_W-1:0]    ratio;
        logic [1:0]            div_sel;
        logic                  power_off;
        logic                  lock;
        pllcm_mode_t           mode;
        logic [LOCK_CNT_W-1:0] lock_cnt;
        logic [31:0]           prdata;
    } pllcm_state_t;

    localparam logic [LOCK_CNT_W-1:0] LOCK_LAST =
        LOCK_CNT_W'(LOCK_CYCLES_P - 1);

    pllcm_state_t state_reg;
    pllcm_state_t state_next;
    logic         rst_meta_reg;
    logic         rst_sync_n_reg;
    logic         setup_phase;
    logic         access_wr;
    logic         addr_hit;
    logic         other_reset;
    logic         ratio_write;
    logic [3:0]   new_ratio;

    // Divide factor from the post-divider select
    function automatic logic [2:0] div_factor(input logic [1:0] sel);
        case (sel)
            DIV_SEL_BY2: div_factor = DIV_BY2;
            DIV_SEL_BY1: div_factor = DIV_BY1;
            default:     div_factor = DIV_BY4; // R6
        endcase
    endfunction

    // Register decode
    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr == ADDR_CLK_OUT)  || (addr == ADDR_STATUS) ||
                 (addr == ADDR_CLK_CTRL) || (addr == ADDR_RATIO);
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_reg   <= 1'b0;
            rst_sync_n_reg <= 1'b0;
        end else begin
            rst_meta_reg   <= 1'b1;
            rst_sync_n_reg <= rst_meta_reg;
        end
    end

    assign setup_phase = psel_i && !penable_i;
    assign access_wr   = psel_i && penable_i && pwrite_i;
    assign addr_hit    = mapped(paddr_i);
    assign other_reset = wdog_reset_i || dbg_reset_i || mclk_reset_i;
    assign new_ratio   = pwdata_i[RATIO_W-1:0];
    assign ratio_write = access_wr && (paddr_i == ADDR_RATIO) &&
                         (new_ratio <= RATIO_MAX);

    always_comb begin
        state_next = state_reg;

        // Pin synchronisers
        state_next.pin19_meta = gpio19_i;
        state_next.pin19_sync = state_reg.pin19_meta;
        state_next.pin38_meta = gpio38_i;
        state_next.pin38_sync = state_reg.pin38_meta;
        if (state_reg.ext_off) begin
            state_next.ext_clk = 1'b0; // R11
        end else if (state_reg.pin_sel) begin
            state_next.ext_clk = state_reg.pin38_sync; // R10
        end else begin
            state_next.ext_clk = state_reg.pin19_sync; // R10
        end

        // Read data captured in the setup cycle
        if (setup_phase && !pwrite_i) begin
            state_next.prdata = 32'h0000_0000;
            case (paddr_i)
                ADDR_CLK_OUT: begin
                    state_next.prdata[POS_PIN_SEL] = state_reg.pin_sel;
                end
                ADDR_STATUS: begin
                    state_next.prdata[POS_LOCK]      = state_reg.lock;
                    state_next.prdata[POS_POWER_OFF] = state_reg.power_off;
                    state_next.prdata[POS_DIV_SEL +: 2] = state_reg.div_sel;
                end
                ADDR_CLK_CTRL: begin
                    state_next.prdata[POS_EXT_OFF]   = state_reg.ext_off;
                    state_next.prdata[POS_XTAL_OFF]  = state_reg.xtal_off;
                    state_next.prdata[POS_OSC_A_OFF] = state_reg.osc_a_off;
                    state_next.prdata[POS_OSC_B_OFF] = state_reg.osc_b_off;
                    state_next.prdata[POS_CORE_SRC +: 2] = state_reg.core_src;
                    state_next.prdata[POS_WDOG_OSC]  = state_reg.wdog_osc;
                    state_next.prdata[POS_TIMER_OSC] = state_reg.timer_osc;
                end
                ADDR_RATIO: begin
                    state_next.prdata[RATIO_W-1:0] = state_reg.ratio;
                end
                default: begin
                    state_next.prdata = 32'h0000_0000;
                end
            endcase
        end

        // Register writes
        if (access_wr) begin
            case (paddr_i)
                ADDR_CLK_OUT: begin
                    state_next.pin_sel = pwdata_i[POS_PIN_SEL]; // R10
                end
                ADDR_STATUS: begin
                    state_next.div_sel   = pwdata_i[POS_DIV_SEL +: 2]; // R6
                    state_next.power_off = pwdata_i[POS_POWER_OFF]; // R13
                end
                ADDR_CLK_CTRL: begin
                    state_next.ext_off   = pwdata_i[POS_EXT_OFF]; // R11
                    state_next.xtal_off  = pwdata_i[POS_XTAL_OFF];
                    state_next.osc_a_off = pwdata_i[POS_OSC_A_OFF];
                    state_next.osc_b_off = pwdata_i[POS_OSC_B_OFF];
                    state_next.core_src  = pwdata_i[POS_CORE_SRC +: 2]; // R9
                    state_next.wdog_osc  = pwdata_i[POS_WDOG_OSC]; // R9
                    state_next.timer_osc = pwdata_i[POS_TIMER_OSC]; // R9
                end
                ADDR_RATIO: begin
                    if (ratio_write) begin
                        state_next.ratio = new_ratio; // R1
                    end
                end
                default: begin
                end
            endcase
        end

        // PLL mode sequencing
        case (state_reg.mode)
            PLLCM_BYPASS, PLLCM_ACTIVE: begin
                if (state_next.power_off) begin
                    state_next.mode = PLLCM_OFF; // R13
                    state_next.lock = 1'b0;
                end else if (ratio_write) begin
                    state_next.mode     = PLLCM_LOCKING; // R16
                    state_next.lock     = 1'b0; // R17
                    state_next.lock_cnt = '0;
                end
            end
            PLLCM_LOCKING: begin
                if (state_next.power_off) begin
                    state_next.mode = PLLCM_OFF; // R13
                    state_next.lock = 1'b0;
                end else if (ratio_write) begin
                    state_next.lock_cnt = '0; // R16
                    state_next.lock     = 1'b0; // R17
                end else if (state_reg.lock_cnt == LOCK_LAST) begin
                    state_next.lock = 1'b1; // R17
                    if (state_reg.ratio == RATIO_BYPASS) begin
                        state_next.mode = PLLCM_BYPASS; // R5
                    end else begin
                        state_next.mode = PLLCM_ACTIVE; // R16
                    end
                end else begin
                    state_next.lock_cnt =
                        state_reg.lock_cnt + LOCK_CNT_W'(1);
                end
            end
            PLLCM_OFF: begin
                if (!state_next.power_off) begin
                    state_next.mode     = PLLCM_LOCKING;
                    state_next.lock     = 1'b0;
                    state_next.lock_cnt = '0;
                end
            end
            default: begin
                state_next.mode = PLLCM_BYPASS;
            end
        endcase

        // Debug and mclk resets spare the ratio and status state; the watchdog reset clears it too
        if (other_reset) begin
            state_next.pin_sel   = 1'b0;
            state_next.ext_off   = 1'b0;
            state_next.xtal_off  = 1'b0;
            state_next.osc_a_off = 1'b0;
            state_next.osc_b_off = 1'b0;
            state_next.core_src  = CORE_SRC_RESET;
            state_next.wdog_osc  = 1'b0;
            state_next.timer_osc = 1'b0;
        end
        if (wdog_reset_i) begin
            state_next.ratio     = RATIO_BYPASS; // R8
            state_next.div_sel   = DIV_SEL_RESET; // R8
            state_next.power_off = 1'b0; // R8
            state_next.lock      = 1'b1;
            state_next.mode      = PLLCM_BYPASS; // R15
            state_next.lock_cnt  = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            state_reg           <= '0;
            state_reg.core_src  <= CORE_SRC_RESET;
            state_reg.ratio     <= RATIO_BYPASS; // R8
            state_reg.div_sel   <= DIV_SEL_RESET; // R6
            state_reg.lock      <= 1'b1;
            state_reg.mode      <= PLLCM_BYPASS; // R15
        end else begin
            state_reg <= state_next;
        end
    end

    // APB answers with no wait states
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_hit;
    assign prdata_o  = state_reg.prdata;

    assign ext_clock_input_o = state_reg.ext_clk;
    assign cpu_div_o         = div_factor(state_reg.div_sel); // R14
    assign cpu_mult_o        = (state_reg.mode == PLLCM_ACTIVE) ?
                               state_reg.ratio : 4'h1; // R5
    assign pll_powered_o     = (state_reg.mode != PLLCM_OFF); // R13
    assign pll_bypass_o      = (state_reg.mode != PLLCM_ACTIVE); // R16
    assign lock_flag_o       = state_reg.lock;
    assign core_src_o        = state_reg.core_src;
    assign wdog_osc_b_o      = state_reg.wdog_osc;
    assign timer_osc_b_o     = state_reg.timer_osc;
    assign xtal_enable_o     = !state_reg.xtal_off;
    assign osc_a_enable_o    = !state_reg.osc_a_off;
    assign osc_b_enable_o    = !state_reg.osc_b_off;

endmodule // pllcm_top

// ### verif/pllcm_chk.sv
// Assertion checker on the PLL clock module ports
`timescale 1ns/10ps
module pllcm_chk
    import pllcm_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES_P = 20
) (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        wdog_reset_i,
    input wire logic        dbg_reset_i,
    input wire logic        mclk_reset_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        ext_clock_input_o,
    input wire logic [3:0]  cpu_mult_o,
    input wire logic [2:0]  cpu_div_o,
    input wire logic        pll_powered_o,
    input wire logic        pll_bypass_o,
    input wire logic        lock_flag_o,
    input wire logic [1:0]  core_src_o,
    input wire logic        wdog_osc_b_o,
    input wire logic        timer_osc_b_o
);
    logic        acc, wr_ratio, wr_stat, wr_ctrl;
    logic [2:0]  div_exp;
    logic [16:0] wait_reg;
    assign acc      = psel_i && penable_i && pwrite_i
                      && !(wdog_reset_i || dbg_reset_i || mclk_reset_i);
    assign wr_ratio = acc && paddr_i == ADDR_RATIO && pwdata_i <= 32'hC;
    assign wr_stat  = acc && paddr_i == ADDR_STATUS;
    assign wr_ctrl  = acc && paddr_i == ADDR_CLK_CTRL;
    assign div_exp  = pwdata_i[3] ? (pwdata_i[2] ? DIV_BY1 : DIV_BY2) : DIV_BY4;
    // Cycles waited for lock since the last restart
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_reg <= 17'h0;
        end else if (wr_ratio || (wr_stat && !pll_powered_o)) begin
            wait_reg <= 17'h0;
        end else if (!lock_flag_o) begin
            wait_reg <= wait_reg + 17'h1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    ratio_write_a: assert property (wr_ratio |=> !lock_flag_o &&
        pll_bypass_o && cpu_mult_o == 4'h1) else $error("no relock");
    lock_time_a: assert property ($rose(lock_flag_o) &&
        !$past(wdog_reset_i) |-> wait_reg == LOCK_CYCLES_P) else $error("lock");
    bypass_mult_a: assert property (pll_bypass_o |-> cpu_mult_o == 4'h1)
        else $error("bypass mult");
    active_lock_a: assert property (!pll_bypass_o |-> lock_flag_o
        && pll_powered_o) else $error("active unlocked");
    div_map_a: assert property (wr_stat |=> cpu_div_o == $past(div_exp))
        else $error("divider");
    pll_off_a: assert property (wr_stat && pwdata_i[1] |=>
        !pll_powered_o && !lock_flag_o && pll_bypass_o) else $error("off");
    wdog_clear_a: assert property (wdog_reset_i |=> lock_flag_o &&
        pll_bypass_o && pll_powered_o && cpu_div_o == DIV_BY4 &&
        cpu_mult_o == 4'h1 && core_src_o == 2'h0) else $error("wdog");
    dbg_keep_a: assert property ((dbg_reset_i || mclk_reset_i) && !psel_i &&
        !wdog_reset_i && lock_flag_o |=> $stable(cpu_div_o) &&
        $stable(cpu_mult_o) && lock_flag_o) else $error("dbg reset");
    src_sel_a: assert property (wr_ctrl |=> {timer_osc_b_o, wdog_osc_b_o,
        core_src_o} == $past(pwdata_i[7:4])) else $error("source");
    ext_off_a: assert property (wr_ctrl && pwdata_i[0] |->
        ##2 !ext_clock_input_o [*6]) else $error("ext off");
    cover property (wr_ratio);
    cover property ($rose(lock_flag_o));
    cover property (dbg_reset_i && lock_flag_o);
    cover property (wr_stat && pwdata_i[1]);
endmodule // pllcm_chk

// ### verif/pllcm_osc_model.sv
// Model of the two external clock pins
`timescale 1ns/10ps
module pllcm_osc_model (
    input  wire logic clk_i,
    output logic      gpio19_o,
    output logic      gpio38_o
);
    logic [1:0] phase_reg = 2'h0;
    // Distinct rates so the pin select shows
    always @(posedge clk_i) begin
        phase_reg <= phase_reg + 2'h1;
    end
    assign gpio19_o = phase_reg[0];
    assign gpio38_o = phase_reg[1];
endmodule // pllcm_osc_model

// ### verif/tb.sv
// Self-checking bench for the PLL clock module
`timescale 1ns/10ps
module tb import pllcm_pkg::*;;
    localparam int LK = 20;
    logic        clk_i = 1'h0, reset_n_i = 1'h0, wdog_reset_i = 1'h0;
    logic        dbg_reset_i = 1'h0, mclk_reset_i = 1'h0, psel_i = 1'h0;
    logic        penable_i = 1'h0, pwrite_i = 1'h0, err_seen;
    logic [7:0]  paddr_i = 8'h0;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd_val;
    logic        pready_o, pslverr_o, gpio19_i, gpio38_i, ext_clock_input_o;
    logic        pll_powered_o, pll_bypass_o, lock_flag_o, wdog_osc_b_o;
    logic        timer_osc_b_o, xtal_enable_o, osc_a_enable_o, osc_b_enable_o;
    logic [3:0]  cpu_mult_o, h19, h38;
    logic [2:0]  cpu_div_o;
    logic [1:0]  core_src_o;
    int          num_errors = 0, num_checks = 0, cyc = 0, n;
    pllcm_osc_model pllcm_osc_model_i (.clk_i(clk_i), .gpio19_o(gpio19_i),
                                       .gpio38_o(gpio38_i));
    pllcm_top #(.LOCK_CYCLES_P(LK)) pllcm_top_i (.*);
    always #5 clk_i = ~clk_i;
    // Pin history and hang guard
    always @(posedge clk_i) begin
        h19 <= {h19[2:0], gpio19_i};
        h38 <= {h38[2:0], gpio38_i};
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            num_errors++;
            conclude();
        end
    end
    task chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'h1;
        do @(posedge clk_i); while (pready_o !== 1'h1);
        rd_val = prdata_o;
        err_seen = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'h0, a, 32'h0);
        chk(nm, e, rd_val);
    endtask
    // Write, then count edges until lock
    task lockw(input logic [7:0] a, input logic [3:0] r);
        wr(a, {28'h0, r});
        n = 0;
        // Watchdog stays quiet until lock is seen
        do begin
            @(posedge clk_i);
            n++;
        end while (lock_flag_o !== 1'h1 && n < 99);
        tick(0);
        chk("lock time", LK + 1, n);
        chk("mult", r == 4'h0 ? 1 : r, cpu_mult_o);
        chk("bypass", r == 4'h0, pll_bypass_o);
    endtask
    task t_defaults;
        rd(ADDR_STATUS, 32'h1, "status");
        rd(ADDR_RATIO, 32'h0, "ratio");
        rd(8'h10, 32'h0, "unmapped");
        chk("slverr", 1, err_seen);
        tick(0);
        chk("div", 4, cpu_div_o);
        chk("mode", 2'h3, {pll_powered_o, pll_bypass_o});
        $display("defaults done");
    endtask
    task t_div;
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_STATUS, 32'(s) << 2);
            tick(0);
            chk("div", s == 3 ? 1 : s == 2 ? 2 : 4, cpu_div_o);
        end
        wr(ADDR_STATUS, 32'h0);
        $display("divider done");
    endtask
    task t_ratio;
        wr(ADDR_RATIO, 32'hC);
        tick(5);
        chk("locking", 2'h1, {lock_flag_o, pll_bypass_o});
        lockw(ADDR_RATIO, 4'h5);
        wr(ADDR_RATIO, 32'hD);
        tick(3);
        chk("ignored", 5, cpu_mult_o);
        lockw(ADDR_RATIO, 4'hC);
        lockw(ADDR_RATIO, 4'h0);
        $display("ratio done");
    endtask
    task t_off;
        wr(ADDR_STATUS, 32'hE);
        tick(0);
        chk("powered", 0, pll_powered_o);
        chk("off div", 1, cpu_div_o);
        chk("off mult", 1, cpu_mult_o);
        lockw(ADDR_STATUS, 4'h0);
        $display("off done");
    endtask
    task t_ext;
        for (int p = 0; p < 2; p++) begin
            wr(ADDR_CLK_OUT, 32'(p));
            tick(4);
            repeat (6) begin
                chk("pin", p ? h38[2] : h19[2], ext_clock_input_o);
                tick(1);
            end
        end
        wr(ADDR_CLK_CTRL, 32'h1);
        tick(3);
        repeat (6) begin
            chk("ext off", 0, ext_clock_input_o);
            tick(1);
        end
        $display("ext done");
    endtask
    task t_src;
        for (int s = 0; s < 16; s++) begin
            wr(ADDR_CLK_CTRL, {24'h0, s[3:0], ~s[2:0], 1'h1});
            tick(0);
            chk("src", s[3:0], {timer_osc_b_o, wdog_osc_b_o, core_src_o});
            chk("osc en", s[2:0], {osc_b_enable_o, osc_a_enable_o, xtal_enable_o});
        end
        $display("source done");
    endtask
    task t_resets;
        lockw(ADDR_RATIO, 4'h7);
        wr(ADDR_STATUS, 32'h8);
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_CLK_CTRL, 32'h30);
            @(posedge clk_i);
            {wdog_reset_i, mclk_reset_i, dbg_reset_i} <= 3'(1 << k);
            @(posedge clk_i);
            {wdog_reset_i, mclk_reset_i, dbg_reset_i} <= 3'h0;
            rd(ADDR_STATUS, k < 2 ? 32'h9 : 32'h1, "status");
            rd(ADDR_RATIO, k < 2 ? 32'h7 : 32'h0, "ratio");
            rd(ADDR_CLK_CTRL, 32'h0, "ctrl");
            tick(0);
            chk("mult", k < 2 ? 7 : 1, cpu_mult_o);
        end
        $display("resets done");
    endtask
    task conclude;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        t_defaults();
        t_div();
        t_ratio();
        t_off();
        t_ext();
        t_src();
        t_resets();
        conclude();
    end
endmodule // tb
bind pllcm_top pllcm_chk #(.LOCK_CYCLES_P(LOCK_CYCLES_P)) pllcm_chk_i (.*);
